// *** core/apm_pkg.sv ***
// Purpose: Shared constants for the fixed-side authentication parameter controller.
// Assumes: One clock (ref_clk, 40 MHz) and a synchronous active-high reset.
// Notes: The challenge-response algorithms sit in an external engine.
// Behaviour
// R1 - Fixed side sends a 64-bit challenge, fresh for every portable response run.
// R2 - Type 2: fixed challenge is also fresh for every fixed response run.
// R3 - Type 1 session seed is 64 bits, made by fixed side, sent to portable.
// R4 - Type 1 seed may be reused; refresh it periodically and on key change.
// R5 - Type 2 wide seed is 128-bit random, used once per key derivation.
// R6 - Wide seed holds high half in top bits, low half below, sent whole.
// R7 - If low half follows type 1 rules, high half is fresh random.
// R8 - Type 2 portable and fixed authentication use different wide seeds.
// R9 - One wide seed serves many portable auths; another serves many fixed auths.
// R10 - Portable computes its 32-bit response and sends it to fixed side.
// R11 - Fixed side passes portable only when response equals expected response.
// R12 - Portable makes a fresh random non-repeating 64-bit challenge per authentication.
// R13 - Portable challenge feeds one process, except during key allocation.
// R14 - Fixed side computes 32-bit fixed response and sends it to portable.
// R15 - Portable accepts fixed side only when expected equals received response.
// R16 - Expected responses never cross the air; only challenges, seeds, responses.
// R17 - Random values must be unpredictable beyond about one half to the sixty-fourth.
// R18 - Freshness comes from a good generator; no history of past values.
// R19 - Every session key is 128 bits wide.
// R20 - One pass or fail result after comparing all 32 bits, held until next start.
package apm_pkg;
  localparam int CHAL_W = 64;
  localparam int HALF_W = 64;
  localparam int WIDE_W = 128;
  localparam int RESP_W = 32;
  localparam int KEY_W = 128;
  // Engine operations.
  localparam logic [1:0] OP_DERIVE_P = 2'h0;
  localparam logic [1:0] OP_DERIVE_F = 2'h1;
  localparam logic [1:0] OP_RESP_P = 2'h2;
  localparam logic [1:0] OP_RESP_F = 2'h3;
  // Air message kinds.
  localparam logic TX_PORT_REQ = 1'b0;
  localparam logic TX_FIX_REPLY = 1'b1;
  localparam logic RX_PORT_RESP = 1'b0;
  localparam logic RX_FIX_REQ = 1'b1;
  // Reset values and the default seed refresh period.
  localparam logic [HALF_W-1:0] RNG_RESET = 64'h9e37_79b9_7f4a_7c15;
  localparam logic [HALF_W-1:0] SEED_RESET = 64'h0;
  localparam int REFRESH_DEFAULT = 40000000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_P_CHAL = 4'h1,
    ST_SEED_HI = 4'h3,
    ST_SEED_LO = 4'h2,
    ST_DERIVE = 4'h6,
    ST_P_SEND = 4'h7,
    ST_P_WAIT = 4'h5,
    ST_P_CHECK = 4'h4,
    ST_F_CHAL = 4'hc,
    ST_F_CALC = 4'hd,
    ST_F_SEND = 4'hf
  } apm_state_t;
endpackage

// *** core/apm_rng.sv ***
// Purpose: 64-bit random source, stepping every clock and stirred by outside entropy.
// Assumes: entropy carries physical noise; without it the sequence is only pseudo-random.
// Notes: Keeps no record of earlier outputs.
`timescale 1ns/1ps
module apm_rng
  import apm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [HALF_W-1:0] entropy,
  output logic [HALF_W-1:0] rand_out
);
  logic [HALF_W-1:0] s_reg;
  logic [HALF_W-1:0] a;
  logic [HALF_W-1:0] b;
  logic [HALF_W-1:0] s_next;

  // Xorshift step folded with entropy; 64 bits of state match the required unpredictability.
  always_comb
  begin
    a = s_reg ^ (s_reg << 13);
    b = a ^ (a >> 7);
    s_next = b ^ (b << 17) ^ entropy; // [R17]
  end

  // Freshness rests on the generator alone, so no list of past values is kept.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s_reg <= RNG_RESET;
    else
      s_reg <= s_next; // [R18]
  end

  assign rand_out = s_reg;
endmodule

// *** core/apm_fixed_ctrl.sv ***
// Purpose: Fixed-side controller: draws challenges and seeds, drives the engine, checks responses.
// Assumes: Engine holds eng_done for one cycle and only while eng_req is high.
// Notes: Air ports carry whole messages in one cycle; framing lies outside.
`timescale 1ns/1ps
module apm_fixed_ctrl
  import apm_pkg::*;
#(
  parameter int SEED_REFRESH_CYCLES = REFRESH_DEFAULT
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic auth_start,
  input wire logic auth_abort,
  input wire logic auth_type2,
  input wire logic new_seed,
  input wire logic split_seed,
  input wire logic key_changed,
  input wire logic [HALF_W-1:0] entropy,
  input wire logic air_rx_valid,
  input wire logic air_rx_kind,
  input wire logic [RESP_W-1:0] air_rx_portable_response,
  input wire logic [CHAL_W-1:0] air_rx_portable_challenge,
  input wire logic eng_done,
  input wire logic [KEY_W-1:0] eng_key_in,
  input wire logic [RESP_W-1:0] eng_resp_in,
  output logic air_tx_valid,
  output logic air_tx_kind,
  output logic air_tx_seed_wide,
  output logic [CHAL_W-1:0] air_tx_fixed_challenge,
  output logic [WIDE_W-1:0] air_tx_seed,
  output logic [RESP_W-1:0] air_tx_fixed_response,
  output logic eng_req,
  output logic [1:0] eng_op,
  output logic eng_wide,
  output logic [WIDE_W-1:0] eng_seed,
  output logic [KEY_W-1:0] eng_key,
  output logic [CHAL_W-1:0] eng_fixed_challenge,
  output logic [CHAL_W-1:0] eng_portable_challenge,
  output logic auth_busy,
  output logic portable_pass,
  output logic portable_fail
);
  apm_state_t state_reg;
  logic [HALF_W-1:0] rnd;
  logic fixed_flow_reg;
  logic wide_reg;
  logic [HALF_W-1:0] seed_hi_reg;
  logic [HALF_W-1:0] session_seed_reg;
  logic [WIDE_W-1:0] port_seed_reg;
  logic [WIDE_W-1:0] fix_seed_reg;
  logic port_seed_ok_reg;
  logic fix_seed_ok_reg;
  logic port_key_ok_reg;
  logic fix_key_ok_reg;
  logic port_key_wide_reg;
  logic fix_key_wide_reg;
  logic [KEY_W-1:0] session_key_reg;
  logic [KEY_W-1:0] fauth_key_reg;
  logic [RESP_W-1:0] rx_resp_reg;
  logic [31:0] refresh_cnt_reg;
  logic refresh_pend_reg;
  logic start_take;
  logic req_take;
  logic refresh_apply;
  logic seed_ok;
  logic key_good;
  logic [WIDE_W-1:0] stored_seed;
  logic [WIDE_W-1:0] other_seed;
  logic other_ok;
  logic [HALF_W-1:0] low_half;
  logic [WIDE_W-1:0] cand_seed;
  logic [CHAL_W-1:0] last_req_chal_reg;
  logic [CHAL_W-1:0] last_rep_chal_reg;
  logic [WIDE_W-1:0] last_derive_seed_reg;

  apm_rng u_rng
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .entropy(entropy),
    .rand_out(rnd)
  );

  // Request takers and per-flow views of the stored seed and key.
  assign start_take = (state_reg == ST_IDLE) && auth_start;
  assign req_take = (state_reg == ST_IDLE) && !auth_start && air_rx_valid
                    && (air_rx_kind == RX_FIX_REQ);
  assign refresh_apply = (state_reg == ST_IDLE) && refresh_pend_reg && !start_take && !req_take;
  assign seed_ok = fixed_flow_reg ? fix_seed_ok_reg : port_seed_ok_reg;
  assign key_good = fixed_flow_reg ? (fix_key_ok_reg && (fix_key_wide_reg == wide_reg))
                                   : (port_key_ok_reg && (port_key_wide_reg == wide_reg));
  assign stored_seed = fixed_flow_reg ? fix_seed_reg : port_seed_reg;
  assign other_seed = fixed_flow_reg ? port_seed_reg : fix_seed_reg;
  assign other_ok = fixed_flow_reg ? port_seed_ok_reg : fix_seed_ok_reg;
  assign low_half = split_seed ? session_seed_reg : rnd; // [R7]
  assign cand_seed = {seed_hi_reg, low_half}; // [R6]

  // Periodic refresh request for the type 1 seed, also raised by a key change.
  // A refresh that falls inside an exchange waits until the controller is idle.
  // It is pending out of reset but a start or request in the same idle cycle wins, so type 1 can still run on the all-zero seed.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      refresh_cnt_reg <= 32'h0;
      refresh_pend_reg <= 1'b1;
    end
    else
    begin
      if (refresh_cnt_reg == 32'(SEED_REFRESH_CYCLES - 1))
        refresh_cnt_reg <= 32'h0;
      else
        refresh_cnt_reg <= refresh_cnt_reg + 32'h1;
      if (key_changed || refresh_cnt_reg == 32'(SEED_REFRESH_CYCLES - 1))
        refresh_pend_reg <= 1'b1; // [R4]
      else if (refresh_apply)
        refresh_pend_reg <= 1'b0;
    end
  end

  // Exchange sequencer with its seeds, keys and engine and air outputs.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      fixed_flow_reg <= 1'b0;
      wide_reg <= 1'b0;
      seed_hi_reg <= SEED_RESET;
      session_seed_reg <= SEED_RESET;
      port_seed_reg <= '0;
      fix_seed_reg <= '0;
      port_seed_ok_reg <= 1'b0;
      fix_seed_ok_reg <= 1'b0;
      port_key_ok_reg <= 1'b0;
      fix_key_ok_reg <= 1'b0;
      port_key_wide_reg <= 1'b0;
      fix_key_wide_reg <= 1'b0;
      session_key_reg <= '0;
      fauth_key_reg <= '0;
      rx_resp_reg <= '0;
      air_tx_valid <= 1'b0;
      air_tx_kind <= TX_PORT_REQ;
      air_tx_seed_wide <= 1'b0;
      air_tx_fixed_challenge <= '0;
      air_tx_seed <= '0;
      air_tx_fixed_response <= '0;
      eng_req <= 1'b0;
      eng_op <= OP_DERIVE_P;
      eng_wide <= 1'b0;
      eng_seed <= '0;
      eng_key <= '0;
      eng_fixed_challenge <= '0;
      eng_portable_challenge <= '0;
      auth_busy <= 1'b0;
    end
    else
    begin
      air_tx_valid <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_take)
          begin
            wide_reg <= auth_type2;
            fixed_flow_reg <= 1'b0;
            auth_busy <= 1'b1;
            state_reg <= ST_P_CHAL;
          end
          else if (req_take)
          begin
            wide_reg <= auth_type2;
            fixed_flow_reg <= 1'b1;
            eng_portable_challenge <= air_rx_portable_challenge;
            auth_busy <= 1'b1;
            state_reg <= ST_F_CHAL;
          end
          else if (refresh_apply)
          begin
            // New type 1 seed and key: every key and wide seed is derived again.
            session_seed_reg <= rnd; // [R4]
            port_key_ok_reg <= 1'b0;
            fix_key_ok_reg <= 1'b0;
            port_seed_ok_reg <= 1'b0;
            fix_seed_ok_reg <= 1'b0;
          end
        end
        ST_P_CHAL, ST_F_CHAL:
        begin
          // Portable runs always draw; type 2 fixed runs draw too, type 1 sends zero.
          if (state_reg == ST_P_CHAL || wide_reg)
            eng_fixed_challenge <= rnd; // [R1] [R2]
          else
            eng_fixed_challenge <= '0;
          // A wide seed whose key is gone is never derived again; a fresh one is drawn.
          if (wide_reg && (!seed_ok || new_seed || !key_good))
            state_reg <= ST_SEED_HI; // [R5]
          else
          begin
            // A valid wide seed and its key are reused across several runs.
            eng_seed <= wide_reg ? stored_seed : {{HALF_W{1'b0}}, session_seed_reg}; // [R9] [R3]
            eng_wide <= wide_reg;
            eng_req <= 1'b1;
            if (!key_good)
            begin
              eng_op <= fixed_flow_reg ? OP_DERIVE_F : OP_DERIVE_P;
              state_reg <= ST_DERIVE;
            end
            else if (fixed_flow_reg)
            begin
              eng_op <= OP_RESP_F;
              eng_key <= fauth_key_reg;
              state_reg <= ST_F_CALC;
            end
            else
            begin
              eng_req <= 1'b0;
              state_reg <= ST_P_SEND;
            end
          end
        end
        ST_SEED_HI:
        begin
          seed_hi_reg <= rnd; // [R7]
          state_reg <= ST_SEED_LO;
        end
        ST_SEED_LO:
        begin
          // The two authentication directions never share a wide seed.
          if (other_ok && cand_seed == other_seed)
            state_reg <= ST_SEED_HI; // [R8]
          else
          begin
            eng_seed <= cand_seed;
            eng_wide <= 1'b1;
            eng_req <= 1'b1;
            eng_op <= fixed_flow_reg ? OP_DERIVE_F : OP_DERIVE_P;
            if (fixed_flow_reg)
            begin
              fix_seed_reg <= cand_seed;
              fix_seed_ok_reg <= 1'b1;
            end
            else
            begin
              port_seed_reg <= cand_seed;
              port_seed_ok_reg <= 1'b1;
            end
            state_reg <= ST_DERIVE;
          end
        end
        ST_DERIVE:
        begin
          if (eng_done)
          begin
            if (fixed_flow_reg)
            begin
              fauth_key_reg <= eng_key_in; // [R19]
              fix_key_ok_reg <= 1'b1;
              fix_key_wide_reg <= wide_reg;
              eng_op <= OP_RESP_F;
              eng_key <= eng_key_in;
              state_reg <= ST_F_CALC;
            end
            else
            begin
              session_key_reg <= eng_key_in; // [R19]
              port_key_ok_reg <= 1'b1;
              port_key_wide_reg <= wide_reg;
              eng_req <= 1'b0;
              state_reg <= ST_P_SEND;
            end
          end
        end
        ST_P_SEND:
        begin
          // Only challenge and seed leave here; the expected value stays inside.
          air_tx_valid <= 1'b1; // [R16]
          air_tx_kind <= TX_PORT_REQ;
          air_tx_seed_wide <= wide_reg;
          air_tx_fixed_challenge <= eng_fixed_challenge;
          air_tx_seed <= eng_seed; // [R6]
          state_reg <= ST_P_WAIT;
        end
        ST_P_WAIT:
        begin
          if (auth_abort)
          begin
            auth_busy <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else if (air_rx_valid && air_rx_kind == RX_PORT_RESP)
          begin
            rx_resp_reg <= air_rx_portable_response;
            eng_portable_challenge <= air_rx_portable_challenge;
            eng_key <= session_key_reg;
            eng_op <= OP_RESP_P;
            eng_req <= 1'b1;
            state_reg <= ST_P_CHECK;
          end
        end
        ST_P_CHECK:
        begin
          if (eng_done)
          begin
            eng_req <= 1'b0;
            auth_busy <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_F_CALC:
        begin
          if (eng_done)
          begin
            eng_req <= 1'b0;
            air_tx_fixed_response <= eng_resp_in; // [R14]
            state_reg <= ST_F_SEND;
          end
        end
        ST_F_SEND:
        begin
          air_tx_valid <= 1'b1; // [R14] [R16]
          air_tx_kind <= TX_FIX_REPLY;
          air_tx_seed_wide <= wide_reg;
          air_tx_fixed_challenge <= eng_fixed_challenge;
          air_tx_seed <= eng_seed;
          auth_busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Verdict of the portable check, cleared only when the next exchange starts.
  // A single full-width compare means all 32 bits are in before any verdict.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      portable_pass <= 1'b0;
      portable_fail <= 1'b0;
    end
    else if (start_take || req_take)
    begin
      portable_pass <= 1'b0;
      portable_fail <= 1'b0;
    end
    else if (state_reg == ST_P_CHECK && eng_done)
    begin
      portable_pass <= (eng_resp_in == rx_resp_reg); // [R11] [R20]
      portable_fail <= (eng_resp_in != rx_resp_reg); // [R20]
    end
  end

  // Helper history used only by the checks below.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      last_req_chal_reg <= '0;
      last_rep_chal_reg <= '0;
      last_derive_seed_reg <= '0;
    end
    else
    begin
      if (air_tx_valid && air_tx_kind == TX_PORT_REQ)
        last_req_chal_reg <= air_tx_fixed_challenge;
      if (air_tx_valid && air_tx_kind == TX_FIX_REPLY)
        last_rep_chal_reg <= air_tx_fixed_challenge;
      if (state_reg == ST_DERIVE && eng_done && eng_wide)
        last_derive_seed_reg <= eng_seed;
    end
  end

  property p_req_chal_fresh;
    @(posedge ref_clk) disable iff (rst)
    (air_tx_valid && air_tx_kind == TX_PORT_REQ) |-> air_tx_fixed_challenge != last_req_chal_reg;
  endproperty
  a_req_chal_fresh: assert property (p_req_chal_fresh) // [R1]
    else $error("Portable request reused the previous fixed challenge.");

  property p_rep_chal_fresh;
    @(posedge ref_clk) disable iff (rst)
    (air_tx_valid && air_tx_kind == TX_FIX_REPLY && air_tx_seed_wide)
      |-> air_tx_fixed_challenge != last_rep_chal_reg;
  endproperty
  a_rep_chal_fresh: assert property (p_rep_chal_fresh) // [R2]
    else $error("Type 2 fixed reply reused the previous fixed challenge.");

  property p_narrow_seed;
    @(posedge ref_clk) disable iff (rst)
    (air_tx_valid && !air_tx_seed_wide)
      |-> air_tx_seed == {{HALF_W{1'b0}}, session_seed_reg};
  endproperty
  a_narrow_seed: assert property (p_narrow_seed) // [R3]
    else $error("Type 1 seed on air differs from the held session seed.");

  property p_derive_once;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_DERIVE && eng_req && eng_wide) |-> eng_seed != last_derive_seed_reg;
  endproperty
  a_derive_once: assert property (p_derive_once) // [R5]
    else $error("Wide seed fed a second key derivation.");

  property p_seed_halves;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_SEED_LO && !(other_ok && cand_seed == other_seed))
      |=> eng_seed[WIDE_W-1:HALF_W] == $past(seed_hi_reg) && state_reg == ST_DERIVE;
  endproperty
  a_seed_halves: assert property (p_seed_halves) // [R6]
    else $error("High seed half is not in the top bits.");

  property p_split_seed;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_SEED_LO && split_seed) |-> seed_hi_reg != session_seed_reg ##1 1'b1;
  endproperty
  a_split_seed: assert property (p_split_seed) // [R7]
    else $error("High half copies the type 1 seed.");

  property p_seeds_differ;
    @(posedge ref_clk) disable iff (rst)
    (air_tx_valid && air_tx_seed_wide && port_seed_ok_reg && fix_seed_ok_reg)
      |-> port_seed_reg != fix_seed_reg;
  endproperty
  a_seeds_differ: assert property (p_seeds_differ) // [R8]
    else $error("Portable and fixed wide seeds are equal.");

  property p_verdict;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_P_CHECK && eng_done)
      |=> portable_pass == ($past(eng_resp_in) == rx_resp_reg) && (portable_pass != portable_fail);
  endproperty
  a_verdict: assert property (p_verdict) // [R11]
    else $error("Portable verdict does not match the response compare.");

  property p_verdict_held;
    @(posedge ref_clk) disable iff (rst)
    (portable_pass && !start_take && !req_take) |=> portable_pass && !portable_fail;
  endproperty
  a_verdict_held: assert property (p_verdict_held) // [R20]
    else $error("Pass verdict dropped before the next exchange.");

  property p_reply_resp;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_F_CALC && eng_done)
      |-> ##2 air_tx_valid && air_tx_kind == TX_FIX_REPLY
          && air_tx_fixed_response == $past(eng_resp_in, 2);
  endproperty
  a_reply_resp: assert property (p_reply_resp) // [R14]
    else $error("Fixed reply missing or not carrying the engine response.");
endmodule

// *** testbench/apm_portable_model.sv ***
// Purpose: Portable-side stand-in that answers challenges and asks for fixed auths.
// Assumes: Each air message is whole in one cycle.
// Notes: bad spoils the answer on purpose; idle fields toggle so no stale value passes.
`timescale 1ns/1ps
module apm_portable_model
  import apm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic air_tx_valid,
  input wire logic air_tx_kind,
  input wire logic [CHAL_W-1:0] air_tx_fixed_challenge,
  input wire logic [WIDE_W-1:0] air_tx_seed,
  input wire logic [RESP_W-1:0] air_tx_fixed_response,
  input wire logic bad,
  input wire logic silent,
  input wire logic ask,
  output logic air_rx_valid,
  output logic air_rx_kind,
  output logic [RESP_W-1:0] air_rx_portable_response,
  output logic [CHAL_W-1:0] air_rx_portable_challenge,
  output logic fix_ok
);
  logic [RESP_W-1:0] resp_reg;
  logic [CHAL_W-1:0] chal_reg;
  int wait_reg;
  // Peer's response sum; the key term is the seed word that the engine rotates into place.
  function automatic logic [RESP_W-1:0] resp_of(input logic [CHAL_W-1:0] c,
    input logic [WIDE_W-1:0] s);
    return c[31:0] ^ c[63:32] ^ s[31:0] ^ s[127:96] ^ s[95:64];
  endfunction
  // Answers go out one to four cycles late, so slow and prompt peers both appear.
  always_ff @(posedge ref_clk)
  begin
    air_rx_valid <= 1'b0;
    air_rx_portable_response <= ~air_rx_portable_response;
    air_rx_portable_challenge <= ~air_rx_portable_challenge;
    if (rst)
    begin
      wait_reg <= 0;
      fix_ok <= 1'b0;
      air_rx_kind <= 1'b0;
      air_rx_portable_response <= '0;
      air_rx_portable_challenge <= '0;
    end
    else if (air_tx_valid && air_tx_kind == TX_PORT_REQ && !silent)
    begin
      resp_reg <= resp_of(air_tx_fixed_challenge, air_tx_seed) ^ {RESP_W{bad}};
      wait_reg <= 1 + $urandom_range(3);
    end
    else if (air_tx_valid && air_tx_kind == TX_FIX_REPLY)
      fix_ok <= air_tx_fixed_response
        === (resp_of(chal_reg, air_tx_seed) ^ air_tx_fixed_challenge[31:0]);
    else if (ask)
    begin
      fix_ok <= 1'b0;
      air_rx_portable_challenge <= {$urandom, $urandom};
      air_rx_kind <= RX_FIX_REQ;
      air_rx_valid <= 1'b1;
    end
    else if (wait_reg == 1)
    begin
      air_rx_kind <= RX_PORT_RESP;
      air_rx_portable_response <= resp_reg;
      air_rx_valid <= 1'b1;
    end
    if (!rst && wait_reg > 0 && !(air_tx_valid && !air_tx_kind))
      wait_reg <= wait_reg - 1;
    // Keep the challenge that really went out, so the reply is checked against it.
    if (air_rx_valid && air_rx_kind == RX_FIX_REQ)
      chal_reg <= air_rx_portable_challenge;
  end
endmodule

// *** testbench/test_apm_fixed_ctrl.sv ***
// Purpose: Self-checking bench for the fixed-side authentication controller.
// Assumes: Engine is modelled here; the portable peer sits in its own file.
// Notes: Seed refresh is set long so no timer refresh lands mid-run.
`timescale 1ns/1ps
module test_apm_fixed_ctrl
  import apm_pkg::*;
;
  logic ref_clk, rst, auth_start, auth_abort, auth_type2, new_seed, split_seed;
  logic key_changed, eng_done, bad, silent, ask, fix_ok, tx_wide, tx_kind;
  logic air_rx_valid, air_rx_kind, air_tx_valid, air_tx_kind, air_tx_seed_wide;
  logic eng_req, eng_wide, auth_busy, portable_pass, portable_fail;
  logic [1:0] eng_op;
  logic [HALF_W-1:0] entropy, low;
  logic [RESP_W-1:0] air_rx_portable_response, air_tx_fixed_response, eng_resp_in;
  logic [CHAL_W-1:0] air_rx_portable_challenge, air_tx_fixed_challenge, tx_chal, prev_chal;
  logic [CHAL_W-1:0] eng_fixed_challenge, eng_portable_challenge;
  logic [WIDE_W-1:0] air_tx_seed, eng_seed, eng_key, eng_key_in, tx_seed, p_seed, f_seed;
  int tx_cnt, eng_lat, err_count, checked;
  apm_fixed_ctrl #(.SEED_REFRESH_CYCLES(100000)) apm_fixed_ctrl_inst (.ref_clk, .rst,
    .auth_start, .auth_abort, .auth_type2, .new_seed, .split_seed, .key_changed, .entropy,
    .air_rx_valid, .air_rx_kind, .air_rx_portable_response, .air_rx_portable_challenge,
    .eng_done, .eng_key_in, .eng_resp_in, .air_tx_valid, .air_tx_kind, .air_tx_seed_wide,
    .air_tx_fixed_challenge, .air_tx_seed, .air_tx_fixed_response, .eng_req, .eng_op,
    .eng_wide, .eng_seed, .eng_key, .eng_fixed_challenge, .eng_portable_challenge,
    .auth_busy, .portable_pass, .portable_fail);
  apm_portable_model apm_portable_model_inst (.ref_clk, .rst, .air_tx_valid, .air_tx_kind,
    .air_tx_fixed_challenge, .air_tx_seed, .air_tx_fixed_response, .bad, .silent, .ask,
    .air_rx_valid, .air_rx_kind, .air_rx_portable_response, .air_rx_portable_challenge,
    .fix_ok);
  // Clock at 40 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Engine stand-in with random latency; answers only from the operands it is handed.
  always @(posedge ref_clk)
  begin
    eng_done <= 1'b0;
    entropy <= {$urandom, $urandom};
    if (rst)
      eng_lat <= 0;
    else if (eng_req && !eng_done && eng_lat == 0)
    begin
      eng_done <= 1'b1;
      eng_lat <= $urandom_range(3);
      // Key is a fixed scramble of the seed, so the peer can rebuild it from the air.
      eng_key_in <= {eng_seed[63:0], eng_seed[127:64]};
      eng_resp_in <= eng_fixed_challenge[31:0] ^ eng_seed[31:0] ^ eng_seed[127:96] ^ eng_key[31:0]
        ^ (eng_op == OP_RESP_F ? eng_portable_challenge[31:0] ^ eng_portable_challenge[63:32]
        : eng_fixed_challenge[63:32]);
    end
    else if (eng_req && !eng_done)
      eng_lat <= eng_lat - 1;
    if (rst)
      tx_cnt <= 0;
    else if (air_tx_valid === 1'b1)
    begin
      tx_cnt <= tx_cnt + 1;
      tx_chal <= air_tx_fixed_challenge;
      tx_seed <= air_tx_seed;
      tx_wide <= air_tx_seed_wide;
      tx_kind <= air_tx_kind;
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input string name);
    int n;
    int c0;
    c0 = tx_cnt;
    n = 0;
    #1;
    while ((auth_busy !== 1'b0 || tx_cnt == c0) && n < 300)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n < 300, 1'b1);
    repeat (3) @(posedge ref_clk);
    #1;
    $display("test %s done", name);
  endtask
  task automatic run_p(input logic t2, ns, sp, bd, input string name);
    logic [WIDE_W-1:0] old;
    old = tx_seed;
    @(posedge ref_clk);
    auth_type2 <= t2;
    new_seed <= ns;
    split_seed <= sp;
    bad <= bd;
    auth_start <= 1'b1;
    @(posedge ref_clk);
    auth_start <= 1'b0;
    settle(name);
    check(portable_pass, !bd);
    check(portable_fail, bd);
    check(tx_wide, t2);
    if (!t2) check(tx_seed[127:64], 0);
    if (t2 && ns) check(tx_seed !== old, 1'b1);
    check(tx_chal !== prev_chal, 1'b1);
    prev_chal = tx_chal;
  endtask
  task automatic run_f(input logic t2, input string name);
    @(posedge ref_clk);
    auth_type2 <= t2;
    ask <= 1'b1;
    @(posedge ref_clk);
    ask <= 1'b0;
    settle(name);
    check(fix_ok, 1'b1);
    check(tx_kind, TX_FIX_REPLY);
    check({portable_pass, portable_fail}, 0);
  endtask
  task automatic give_verdict;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run the normal way.
  initial
  begin
    #(25 * 20000);
    err_count++;
    give_verdict();
  end
  // Hand-written corner cases first, then random portable exchanges.
  initial
  begin
    void'($urandom(32'h05d2));
    {rst, auth_start, auth_abort, auth_type2, new_seed, split_seed, key_changed} = 7'h40;
    {bad, silent, ask, err_count, checked} = '0;
    prev_chal = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    run_p(1'b0, 1'b0, 1'b0, 1'b0, "type1 pass");
    run_p(1'b0, 1'b0, 1'b0, 1'b1, "type1 fail");
    low = tx_seed[63:0];
    @(posedge ref_clk);
    silent <= 1'b1;
    auth_start <= 1'b1;
    @(posedge ref_clk);
    auth_start <= 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 check(auth_busy, 1'b1);
    @(posedge ref_clk);
    auth_abort <= 1'b1;
    silent <= 1'b0;
    @(posedge ref_clk);
    auth_abort <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check({auth_busy, portable_pass, portable_fail}, 0);
    $display("test abort done");
    run_f(1'b0, "type1 fixed");
    check(tx_chal, 0);
    run_p(1'b1, 1'b1, 1'b0, 1'b0, "type2 new seed");
    p_seed = tx_seed;
    run_f(1'b1, "type2 fixed a");
    f_seed = tx_seed;
    check(f_seed !== p_seed, 1'b1);
    prev_chal = tx_chal;
    run_f(1'b1, "type2 fixed b");
    check(tx_chal !== prev_chal, 1'b1);
    run_p(1'b1, 1'b0, 1'b0, 1'b0, "type2 reuse");
    check(tx_seed !== f_seed, 1'b1);
    check(tx_seed, p_seed);
    run_p(1'b1, 1'b1, 1'b1, 1'b0, "split seed");
    check(tx_seed[63:0], low);
    @(posedge ref_clk);
    key_changed <= 1'b1;
    @(posedge ref_clk);
    key_changed <= 1'b0;
    run_p(1'b0, 1'b0, 1'b0, 1'b0, "key change");
    check(tx_seed[63:0] !== low, 1'b1);
    repeat (16) run_p($urandom_range(1), $urandom_range(1), $urandom_range(1),
      $urandom_range(1), "random");
    give_verdict();
  end
endmodule
